/* File: hw/phy_mgmt_pkg.sv */
// Constants, layouts and carrier types of the per-port PHY management registers
// Summary of operation
// - Ports 1 to 5 answer at addresses 1 to 5
// - Only register addresses 0-5, 1D, 1F exist
// - Same registers also reachable through SPI mapping
// - Control bit 15 soft-resets port, self-clears
// - Control bit 13 selects 100 or 10 Mbps
// - Bit 12 enables negotiation, bit 9 restarts it
// - Bit 10 isolates PHY, bit 11 powers down
// - Control bit 8 forces full or half duplex
// - Control bit 5 picks crossover style, default one
// - Control bit 4 forces straight-through pair use
// - Control bit 3 disables automatic crossover detection
// - Bit 2 disables far-end fault, bit 1 transmit
// - Bit 0 disables LEDs; bits 7, 6 read zero
// - Status capability bits 14-11 and 3 read one
// - Status bits 15, 10-6, 1, 0 read zero
// - Status bit 2 shows live link state
// - Status bit 5 shows negotiation complete
// - Status bit 4 shows far-end fault detected
// - Registers 2 and 3 return fixed identifier
// - Advert bit 10 pause, bits 15, 13 zero
// - Advert bits 8-5 writable, selector reads 00001
// - Partner bit 10 pause; bits 15-13 read zero
// - Partner bits 8-5 report abilities, reset zero
package phy_mgmt_pkg;

   localparam int          NUM_PORTS    = 5;
   localparam logic [4:0]  FIRST_PHYAD  = 5'h01;
   localparam logic [5:0]  PREAMBLE_LEN = 6'h20;

   localparam logic [4:0]  REG_CTRL     = 5'h00;
   localparam logic [4:0]  REG_STATUS   = 5'h01;
   localparam logic [4:0]  REG_ID_HIGH  = 5'h02;
   localparam logic [4:0]  REG_ID_LOW   = 5'h03;
   localparam logic [4:0]  REG_ADV      = 5'h04;
   localparam logic [4:0]  REG_PARTNER  = 5'h05;
   localparam logic [4:0]  REG_CABLE    = 5'h1D;
   localparam logic [4:0]  REG_SPECIAL  = 5'h1F;

   localparam int          CB_SOFT_RESET = 15;
   localparam int          CB_RESTART    = 9;
   localparam logic [15:0] CTRL_RST     = 16'h3020;
   localparam logic [15:0] CTRL_WMASK   = 16'hFF3F;
   localparam logic [15:0] ADV_RST      = 16'h05E1;
   localparam logic [15:0] ADV_WMASK    = 16'h05E0;
   localparam logic [15:0] LP_MASK      = 16'h05E0;
   localparam logic [15:0] STAT_FIXED   = 16'h7808;
   localparam int          SB_AN_DONE   = 5;
   localparam int          SB_FAR_FAULT = 4;
   localparam int          SB_LINK      = 2;

   localparam logic [1:0]  OP_READ      = 2'h2;
   localparam logic [1:0]  OP_WRITE     = 2'h1;

   typedef enum logic [2:0] {
      FSM_IDLE  = 3'b000,
      FSM_START = 3'b001,
      FSM_HEAD  = 3'b010,
      FSM_TA    = 3'b011,
      FSM_DATA  = 3'b100
   } mgmt_fsm_e;

   // What the PHY core of one port reports
   typedef struct packed {
      logic        link_up;
      logic        an_done;
      logic        far_fault;
      logic        lp_valid;
      logic [15:0] lp_word;
   } phy_in_s;

   // Register copies that steer one port
   typedef struct packed {
      logic [15:0] ctrl;
      logic [15:0] adv;
   } port_cfg_s;

   typedef struct packed {
      mgmt_fsm_e       fsm;
      logic [1:0]      mdc_s;
      logic            mdc_prev;
      logic [1:0]      mdio_s;
      logic [5:0]      pre_cnt;
      logic [3:0]      cnt;
      logic [10:0]     hdr;
      logic [15:0]     shreg;
      logic            rd;
      logic            hit;
      logic [2:0]      port;
      logic [4:0]      regad;
      logic            mdio_o;
      logic            mdio_oe;
      logic [4:0][15:0] ctrl;
      logic [4:0][15:0] adv;
      logic [4:0][15:0] lp;
      logic [15:0]     spi_rdata;
      logic            spi_ack;
   } state_s;

   localparam state_s STATE_RST = '{
      fsm:   FSM_IDLE,
      ctrl:  {5{CTRL_RST}},
      adv:   {5{ADV_RST}},
      default: '0
   };

endpackage

/* File: hw/phy_mgmt_regs.sv */
// Per-port PHY management registers with serial management and SPI access
`timescale 1ns/1ps
`default_nettype none
module phy_mgmt_regs
   import phy_mgmt_pkg::*;
#(
   parameter logic [15:0] ID_HIGH = 16'h1234,  // Arbitrary value
   parameter logic [15:0] ID_LOW  = 16'h5670   // Arbitrary value
) (
   input  wire logic                    i_clk,
   input  wire logic                    i_rst_b,
   input  wire logic                    i_mdc,
   input  wire logic                    i_mdio,
   output logic                         o_mdio,
   output logic                         o_mdio_oe,
   input  wire logic                    i_spi_req,
   input  wire logic                    i_spi_wr,
   input  wire logic [7:0]              i_spi_addr,
   input  wire logic [15:0]             i_spi_wdata,
   output logic [15:0]                  o_spi_rdata,
   output logic                         o_spi_ack,
   input  wire phy_in_s [NUM_PORTS-1:0] i_phy,
   output port_cfg_s [NUM_PORTS-1:0]    o_cfg
);

   state_s st_q;
   state_s st_d;
   logic   mdc_rise;
   logic   mdio_bit;
   logic   mdio_wr_now;
   logic   spi_take;

   // ---------------------------------------------------------------
   // Register read and write decode
   // ---------------------------------------------------------------
   function automatic logic [15:0] read_word(
      input state_s  s,
      input phy_in_s ph,
      input logic [2:0] p,
      input logic [4:0] ra
   );
      logic [15:0] w;
      w = 16'h0000;
      if (p < 3'(NUM_PORTS)) begin
         case (ra)
            REG_CTRL:    w = s.ctrl[p];
            REG_STATUS: begin
               w = STAT_FIXED;
               w[SB_LINK]      = ph.link_up;
               w[SB_AN_DONE]   = ph.an_done;
               w[SB_FAR_FAULT] = ph.far_fault;
            end
            REG_ID_HIGH: w = ID_HIGH;
            REG_ID_LOW:  w = ID_LOW;
            REG_ADV:     w = s.adv[p];
            REG_PARTNER: w = s.lp[p];
            // Diagnostic and special words hold no fields here yet
            REG_CABLE:   w = 16'h0000;
            REG_SPECIAL: w = 16'h0000;
            default:     w = 16'h0000;
         endcase
      end
      return w;
   endfunction

   function automatic state_s reg_write(
      input state_s s,
      input logic [2:0] p,
      input logic [4:0] ra,
      input logic [15:0] v
   );
      state_s r;
      r = s;
      if (p < 3'(NUM_PORTS)) begin
         case (ra)
            REG_CTRL: begin
               r.ctrl[p] = (s.ctrl[p] & ~CTRL_WMASK) | (v & CTRL_WMASK);
               if (v[CB_RESTART]) begin
                  r.lp[p] = 16'h0000;
               end
            end
            REG_ADV: begin
               r.adv[p] = (s.adv[p] & ~ADV_WMASK) | (v & ADV_WMASK);
            end
            default: r = s;
         endcase
      end
      return r;
   endfunction

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   assign mdc_rise = st_q.mdc_s[1] & ~st_q.mdc_prev;
   assign mdio_bit = st_q.mdio_s[1];
   assign mdio_wr_now = mdc_rise && (st_q.fsm == FSM_DATA) &&
                        (st_q.cnt == 4'hF) && st_q.hit && !st_q.rd;
   // The serial write wins a collision; SPI simply waits a cycle
   assign spi_take = i_spi_req && !st_q.spi_ack && !mdio_wr_now;

   always_comb begin
      logic [11:0] full;
      logic [2:0]  pidx;
      full = {st_q.hdr, mdio_bit};
      pidx = 3'(full[9:5] - FIRST_PHYAD);
      st_d = st_q;
      st_d.mdc_s    = {st_q.mdc_s[0], i_mdc};
      st_d.mdc_prev = st_q.mdc_s[1];
      st_d.mdio_s   = {st_q.mdio_s[0], i_mdio};
      st_d.spi_ack  = 1'b0;

      for (int p = 0; p < NUM_PORTS; p++) begin
         if (st_q.ctrl[p][CB_SOFT_RESET]) begin
            // Soft reset is seen for one cycle, then defaults return
            st_d.ctrl[p] = CTRL_RST;
            st_d.adv[p]  = ADV_RST;
            st_d.lp[p]   = 16'h0000;
         end
      end

      if (mdc_rise) begin
         case (st_q.fsm)
            FSM_IDLE: begin
               if (mdio_bit) begin
                  if (st_q.pre_cnt < PREAMBLE_LEN) begin
                     st_d.pre_cnt = st_q.pre_cnt + 6'h01;
                  end
               end else if (st_q.pre_cnt >= PREAMBLE_LEN) begin
                  st_d.fsm = FSM_START;
               end else begin
                  st_d.pre_cnt = 6'h00;
               end
            end
            FSM_START: begin
               st_d.pre_cnt = 6'h00;
               st_d.cnt     = 4'h0;
               st_d.fsm     = mdio_bit ? FSM_HEAD : FSM_IDLE;
            end
            FSM_HEAD: begin
               st_d.hdr = full[10:0];
               st_d.cnt = st_q.cnt + 4'h1;
               if (st_q.cnt == 4'hB) begin
                  st_d.rd    = (full[11:10] == OP_READ);
                  // Any other port address is left to other PHYs
                  st_d.hit   = ((full[11:10] == OP_READ) ||
                                (full[11:10] == OP_WRITE)) &&
                               (full[9:5] >= FIRST_PHYAD) &&
                               ((full[9:5] - FIRST_PHYAD) <
                                5'(NUM_PORTS));
                  st_d.port  = pidx;
                  st_d.regad = full[4:0];
                  st_d.shreg = read_word(st_q, i_phy[pidx], pidx,
                                         full[4:0]);
                  st_d.cnt   = 4'h0;
                  st_d.fsm   = FSM_TA;
               end
            end
            FSM_TA: begin
               if (st_q.cnt == 4'h0) begin
                  st_d.cnt = 4'h1;
                  if (st_q.rd && st_q.hit) begin
                     st_d.mdio_oe = 1'b1;
                     st_d.mdio_o  = 1'b0;
                  end
               end else begin
                  st_d.cnt = 4'h0;
                  st_d.fsm = FSM_DATA;
                  if (st_q.rd && st_q.hit) begin
                     st_d.mdio_o = st_q.shreg[15];
                     st_d.shreg  = {st_q.shreg[14:0], 1'b0};
                  end
               end
            end
            FSM_DATA: begin
               st_d.cnt = st_q.cnt + 4'h1;
               if (st_q.rd) begin
                  st_d.mdio_o = st_q.shreg[15];
                  st_d.shreg  = {st_q.shreg[14:0], 1'b0};
               end else begin
                  st_d.shreg  = {st_q.shreg[14:0], mdio_bit};
               end
               if (st_q.cnt == 4'hF) begin
                  st_d.mdio_oe = 1'b0;
                  st_d.mdio_o  = 1'b0;
                  st_d.hit     = 1'b0;
                  st_d.fsm     = FSM_IDLE;
               end
            end
            default: st_d.fsm = FSM_IDLE;
         endcase
      end

      if (mdio_wr_now) begin
         st_d = reg_write(st_d, st_q.port, st_q.regad,
                          {st_q.shreg[14:0], mdio_bit});
      end

      // ---------------------------------------------------------------
      // SPI side: port index in the top bits, register in the low bits
      // ---------------------------------------------------------------
      if (spi_take) begin
         st_d.spi_ack = 1'b1;
         st_d.spi_rdata = read_word(st_q, i_phy[i_spi_addr[7:5]],
                                    i_spi_addr[7:5], i_spi_addr[4:0]);
         if (i_spi_wr) begin
            st_d = reg_write(st_d, i_spi_addr[7:5], i_spi_addr[4:0],
                             i_spi_wdata);
         end
      end

      // A fresh capture beats a restart write landing in the same cycle
      for (int p = 0; p < NUM_PORTS; p++) begin
         if (i_phy[p].lp_valid && !st_q.ctrl[p][CB_SOFT_RESET]) begin
            st_d.lp[p] = i_phy[p].lp_word & LP_MASK;
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         st_q <= STATE_RST;
      end else begin
         st_q <= st_d;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign o_mdio      = st_q.mdio_o;
   assign o_mdio_oe   = st_q.mdio_oe;
   assign o_spi_rdata = st_q.spi_rdata;
   assign o_spi_ack   = st_q.spi_ack;

   always_comb begin
      for (int p = 0; p < NUM_PORTS; p++) begin
         o_cfg[p] = '{ctrl: st_q.ctrl[p], adv: st_q.adv[p]};
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   property p_drive_only_hit;
      @(posedge i_clk) disable iff (!i_rst_b)
      o_mdio_oe |-> st_q.hit && st_q.rd;
   endproperty
   a_drive_only_hit: assert property (p_drive_only_hit)
      else $error("Management line driven for a foreign address");

   property p_ta_low;
      @(posedge i_clk) disable iff (!i_rst_b)
      $rose(o_mdio_oe) |-> !o_mdio && st_q.fsm == FSM_TA;
   endproperty
   a_ta_low: assert property (p_ta_low)
      else $error("Turnaround bit not driven low");

   property p_soft_reset;
      @(posedge i_clk) disable iff (!i_rst_b)
      st_q.ctrl[3][CB_SOFT_RESET] |=>
         st_q.ctrl[3] == CTRL_RST && st_q.adv[3] == ADV_RST;
   endproperty
   a_soft_reset: assert property (p_soft_reset)
      else $error("Soft reset did not self-clear to defaults");

   property p_ctrl_zero_bits;
      @(posedge i_clk) disable iff (!i_rst_b)
      ##1 (o_cfg[1].ctrl[7:6] == 2'h0 && o_cfg[4].ctrl[7:6] == 2'h0);
   endproperty
   a_ctrl_zero_bits: assert property (p_ctrl_zero_bits)
      else $error("Control bits 7 or 6 not zero");

   property p_adv_fixed;
      @(posedge i_clk) disable iff (!i_rst_b)
      ##1 (o_cfg[2].adv[4:0] == 5'h01 && o_cfg[2].adv[15:11] == 5'h00);
   endproperty
   a_adv_fixed: assert property (p_adv_fixed)
      else $error("Advertisement fixed fields wrong");

   property p_status_read;
      @(posedge i_clk) disable iff (!i_rst_b)
      (spi_take && i_spi_addr == {3'h0, REG_STATUS}) |=>
         o_spi_ack && o_spi_rdata[15:11] == 5'h0F && o_spi_rdata[3] &&
         o_spi_rdata[2] == $past(i_phy[0].link_up);
   endproperty
   a_status_read: assert property (p_status_read)
      else $error("Status word read wrong");

   property p_unmapped_zero;
      @(posedge i_clk) disable iff (!i_rst_b)
      (spi_take && i_spi_addr[4:0] == 5'h06) |=> o_spi_rdata == 16'h0000;
   endproperty
   a_unmapped_zero: assert property (p_unmapped_zero)
      else $error("Unimplemented register did not read zero");

   property p_spi_served;
      @(posedge i_clk) disable iff (!i_rst_b)
      (i_spi_req && !o_spi_ack) |-> ##[0:2] spi_take;
   endproperty
   a_spi_served: assert property (p_spi_served)
      else $error("SPI request not served in time");

   property p_lp_capture;
      @(posedge i_clk) disable iff (!i_rst_b)
      (i_phy[0].lp_valid && !st_q.ctrl[0][CB_SOFT_RESET]) |=>
         st_q.lp[0] == ($past(i_phy[0].lp_word) & LP_MASK);
   endproperty
   a_lp_capture: assert property (p_lp_capture)
      else $error("Partner ability not captured");

   property p_restart_clears;
      @(posedge i_clk) disable iff (!i_rst_b)
      (spi_take && i_spi_wr && i_spi_addr == {3'h1, REG_CTRL} &&
       i_spi_wdata[CB_RESTART] && !i_phy[1].lp_valid) |=>
         st_q.lp[1] == 16'h0000;
   endproperty
   a_restart_clears: assert property (p_restart_clears)
      else $error("Restart did not clear partner word");

   property p_oe_fall;
      @(posedge i_clk) disable iff (!i_rst_b)
      $fell(o_mdio_oe) |-> st_q.fsm == FSM_IDLE && !st_q.hit;
   endproperty
   a_oe_fall: assert property (p_oe_fall)
      else $error("Management line held past the last data bit");

   property p_adv_write;
      @(posedge i_clk) disable iff (!i_rst_b)
      (mdio_wr_now && st_q.port == 3'h1 && st_q.regad == REG_ADV) |=>
         o_cfg[1].adv == (({$past(st_q.shreg[14:0]), $past(mdio_bit)} &
                           ADV_WMASK) | (ADV_RST & ~ADV_WMASK));
   endproperty
   a_adv_write: assert property (p_adv_write)
      else $error("Serial write did not land in advertisement word");

   property p_ack_pulse;
      @(posedge i_clk) disable iff (!i_rst_b)
      o_spi_ack |=> !o_spi_ack;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse)
      else $error("SPI acknowledge stood longer than one cycle");

   property p_reset_values;
      @(posedge i_clk) disable iff (!i_rst_b)
      $rose(i_rst_b) |-> o_cfg[0].ctrl[13] && o_cfg[0].ctrl[12] &&
         o_cfg[0].ctrl[5] && !o_cfg[0].ctrl[15] && o_cfg[0].adv[10] &&
         o_cfg[0].adv[8:5] == 4'hF;
   endproperty
   a_reset_values: assert property (p_reset_values)
      else $error("Register defaults wrong after reset");

endmodule
`default_nettype wire

/* File: tb/mdio_station.sv */
// Management station model that drives MDC and MDIO frames
`timescale 1ns/1ps
`default_nettype none
module mdio_station (
   output logic      o_mdc,
   output logic      o_oe,
   output logic      o_dat,
   input  wire logic i_line
);
   initial begin
      o_mdc = 1'b0;
      o_oe  = 1'b0;
      o_dat = 1'b0;
   end

   // -------------------------------------------------------------
   // One 80 ns beat; MDC stands low between frames
   // -------------------------------------------------------------
   task automatic beat(input logic drv, input logic v, output logic smp);
      o_oe  = drv;
      o_dat = v;
      #40 o_mdc = 1'b1;
      // Sampled before the block can react to this rise
      smp = i_line;
      #40 o_mdc = 1'b0;
   endtask

   // Reads release the line from the turnaround on; rd = {TA2, data}
   task automatic frame(input logic [1:0] op, input logic [4:0] ad,
                        input logic [4:0] ra, input logic [15:0] wd,
                        output logic [16:0] rd);
      logic [45:0] hdr;
      logic [17:0] w;
      logic        s;
      hdr = {32'hFFFFFFFF, 2'b01, op, ad, ra};
      w = {2'b10, wd};
      rd = '1;
      // Keeps MDC edges off the phase of the block's clock
      #1.3;
      for (int i = 45; i >= 0; i--) begin
         beat(1'b1, hdr[i], s);
      end
      for (int i = 17; i >= 0; i--) begin
         beat(op == 2'b01, w[i], s);
         if (i < 17) begin
            rd[i] = s;
         end
      end
      o_oe = 1'b0;
   endtask
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
// Self-checking bench for the per-port PHY management registers
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import phy_mgmt_pkg::*;
   // Arbitrary identifier values
   localparam logic [15:0] IDH = 16'hA5C3;
   localparam logic [15:0] IDL = 16'h0F96;
   localparam logic [4:0]  RA_L [10] = '{5'h00, 5'h01, 5'h02, 5'h03,
      5'h04, 5'h05, 5'h06, 5'h1D, 5'h1E, 5'h1F};
   logic                      i_clk;
   logic                      i_rst_b;
   logic                      mdc;
   logic                      mdio_w;
   logic                      dut_o;
   logic                      dut_oe;
   logic                      st_o;
   logic                      st_oe;
   logic                      spi_req;
   logic                      spi_wr;
   logic                      spi_ack;
   logic [7:0]                spi_addr;
   logic [15:0]               spi_wd;
   logic [15:0]               spi_rd;
   phy_in_s [NUM_PORTS-1:0]   phy;
   port_cfg_s [NUM_PORTS-1:0] cfg;
   logic [15:0]               ctrl_m [5];
   logic [15:0]               adv_m [5];
   logic [15:0]               lp_m [5];
   logic [15:0]               d;
   logic [16:0]               rd;
   int                        n_mismatch;
   int                        checks;
   integer                    seed;

   // Line has a pull-up: released means high
   assign mdio_w = dut_oe ? dut_o : (st_oe ? st_o : 1'b1);

   phy_mgmt_regs #(.ID_HIGH(IDH), .ID_LOW(IDL)) i_dut (
      .i_clk(i_clk), .i_rst_b(i_rst_b), .i_mdc(mdc), .i_mdio(mdio_w),
      .o_mdio(dut_o), .o_mdio_oe(dut_oe), .i_spi_req(spi_req),
      .i_spi_wr(spi_wr), .i_spi_addr(spi_addr), .i_spi_wdata(spi_wd),
      .o_spi_rdata(spi_rd), .o_spi_ack(spi_ack), .i_phy(phy),
      .o_cfg(cfg));

   mdio_station i_sta (.o_mdc(mdc), .o_oe(st_oe), .o_dat(st_o),
      .i_line(mdio_w));

   initial begin
      i_clk = 1'b0;
      forever #2.5 i_clk = ~i_clk;
   end

   // -------------------------------------------------------------
   // Checking and reference model
   // -------------------------------------------------------------
   task automatic close_out;
      if (n_mismatch == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask

   function automatic logic [15:0] exp_rd(input int p, input logic [4:0] ra);
      if (p >= 5)
         return 16'h0000;
      case (ra)
         5'h00: return ctrl_m[p];
         5'h01: return 16'h7808 | {10'h000, phy[p].an_done,
                   phy[p].far_fault, 1'b0, phy[p].link_up, 2'b00};
         5'h02: return IDH;
         5'h03: return IDL;
         5'h04: return adv_m[p];
         5'h05: return lp_m[p];
         default: return 16'h0000;
      endcase
   endfunction

   function automatic void model_wr(int p, logic [4:0] ra, logic [15:0] v);
      if (ra == 5'h00 && v[15]) begin
         ctrl_m[p] = 16'h3020;
         adv_m[p] = 16'h05E1;
         lp_m[p] = 16'h0000;
      end else if (ra == 5'h00) begin
         ctrl_m[p] = v & 16'hFF3F;
         if (v[9])
            lp_m[p] = 16'h0000;
      end else if (ra == 5'h04) begin
         adv_m[p] = (v & 16'h05E0) | 16'h0001;
      end
   endfunction

   task automatic spi(input logic w, input logic [7:0] a,
                      input logic [15:0] v, output logic [15:0] r);
      int n;
      @(negedge i_clk);
      spi_req = 1'b1;
      spi_wr = w;
      spi_addr = a;
      spi_wd = v;
      n = 0;
      do begin
         @(negedge i_clk);
         n++;
      end while (spi_ack !== 1'b1 && n < 8);
      if (spi_ack !== 1'b1) begin
         n_mismatch++;
         close_out();
      end
      r = spi_rd;
      spi_req = 1'b0;
   endtask

   task automatic wr(input int p, input logic [4:0] ra, input logic [15:0] v);
      logic [15:0] r;
      spi(1'b1, {p[2:0], ra}, v, r);
      chk("spi_old", exp_rd(p, ra), r);
      if (p < 5)
         model_wr(p, ra, v);
   endtask

   // Live status moves before every sweep
   task automatic sweep;
      logic [15:0] r;
      @(negedge i_clk);
      for (int p = 0; p < 5; p++) begin
         phy[p].link_up = seed[p];
         phy[p].an_done = 1'($random(seed));
         phy[p].far_fault = 1'($random(seed));
      end
      for (int p = 0; p < 8; p++) begin
         for (int k = 0; k < 10; k++) begin
            spi(1'b0, {p[2:0], RA_L[k]}, 16'h0000, r);
            chk("spi_rd", exp_rd(p, RA_L[k]), r);
         end
      end
      for (int p = 0; p < 5; p++) begin
         chk("cfg_ctrl", ctrl_m[p], cfg[p].ctrl);
         chk("cfg_adv", adv_m[p], cfg[p].adv);
      end
   endtask

   // -------------------------------------------------------------
   // Main sequence
   // -------------------------------------------------------------
   initial begin
      repeat (80000) @(posedge i_clk);
      n_mismatch++;
      close_out();
   end

   initial begin
      seed = 32'h9FEE;
      n_mismatch = 0;
      checks = 0;
      i_rst_b = 1'b0;
      spi_req = 1'b0;
      spi_wr = 1'b0;
      spi_addr = 8'h00;
      spi_wd = 16'h0000;
      phy = '0;
      for (int p = 0; p < 5; p++) begin
         ctrl_m[p] = 16'h3020;
         adv_m[p] = 16'h05E1;
         lp_m[p] = 16'h0000;
      end
      repeat (4) @(negedge i_clk);
      i_rst_b = 1'b1;
      sweep();
      for (int it = 0; it < 3; it++) begin
         for (int p = 0; p < 8; p++) begin
            for (int k = 0; k < 10; k++) begin
               d = (it == 0) ? 16'hFFFF : 16'($random(seed));
               d = (it == 1) ? 16'h0000 : d;
               wr(p, RA_L[k], (RA_L[k] == 5'h00) ? d & 16'h7DFF : d);
            end
         end
         sweep();
      end
      for (int p = 0; p < 5; p++) begin
         @(negedge i_clk);
         d = 16'($random(seed)) | 16'h0400;
         phy[p].lp_word = d;
         phy[p].lp_valid = 1'b1;
         lp_m[p] = d & 16'h05E0;
         @(negedge i_clk);
         phy[p].lp_valid = 1'b0;
         phy[p].lp_word = ~d;
      end
      sweep();
      wr(1, 5'h00, 16'h1200);
      sweep();
      wr(3, 5'h00, 16'hFFFF);
      sweep();
      for (int a = 0; a < 8; a++) begin
         for (int k = 0; k < 2; k++) begin
            i_sta.frame(2'b10, a[4:0], RA_L[4*k], 16'h0000, rd);
            chk("mdio_rd", (a >= 1 && a <= 5) ?
               {1'b0, exp_rd(a - 1, RA_L[4*k])} : 17'h1FFFF, rd);
         end
         d = 16'($random(seed));
         i_sta.frame(2'b01, a[4:0], 5'h04, d, rd);
         if (a >= 1 && a <= 5)
            model_wr(a - 1, 5'h04, d);
      end
      i_sta.frame(2'b11, 5'h01, 5'h00, 16'h0000, rd);
      chk("mdio_op", 17'h1FFFF, rd);
      i_sta.frame(2'b00, 5'h01, 5'h00, 16'h0000, rd);
      chk("mdio_op", 17'h1FFFF, rd);
      i_sta.frame(2'b10, 5'h09, 5'h00, 16'h0000, rd);
      chk("mdio_far_ad", 17'h1FFFF, rd);
      sweep();
      close_out();
   end
endmodule
`default_nettype wire
